/* rtl/afs_defines.svh */
/*
 * Offsets, field positions and reset values of the amplifier fault status registers.
 * Assumes inclusion by bare name from design files; definitions only.
 */
`ifndef AFS_DEFINES_SVH
`define AFS_DEFINES_SVH

// register offsets
`define AFS_ADDR_SUPPLY_STATUS  8'h11
`define AFS_ADDR_THERMAL_MEM    8'h12
`define AFS_ADDR_THERMAL_STATUS 8'h13
`define AFS_ADDR_LOAD_MEM       8'h14

// reset values and the value read at unmapped offsets
`define AFS_RST_BYTE            8'h00
`define AFS_RST_THERMAL_MEM     6'h00
`define AFS_RST_LOAD_MEM        4'h0
`define AFS_READ_ZERO           8'h00

// supply status fields
`define AFS_SUP_WARN_BIT        7
`define AFS_SUP_FAULT_BIT       6
`define AFS_SUP_GATE_BIT        5
`define AFS_SUP_PS_OV_BIT       3
`define AFS_SUP_BAT_OV_BIT      2
`define AFS_SUP_PS_UV_BIT       1
`define AFS_SUP_BAT_UV_BIT      0

// thermal/clock fields of the status register; bits 5..0 shared with memory
`define AFS_TC_WARN_BIT         7
`define AFS_TC_FAULT_BIT        6
`define AFS_TC_CLK_BIT          5
`define AFS_TC_OVERTEMP_SHUTDOWN_BIT         4
`define AFS_TC_CH_MSB           3

`endif

/* rtl/afs_pkg.sv */
/*
 * Types of the amplifier fault status register bank.
 * Assumes afs_defines.svh holds every number.
 */
package afs_pkg;

   typedef logic [7:0] afs_byte_t;

   // live supply conditions
   typedef struct packed {
      logic any_warning;
      logic any_fault;
      logic gate_drive_regulator_fault;
      logic power_stage_supply_ov;
      logic battery_supply_ov;
      logic power_stage_supply_uv;
      logic battery_supply_uv;
   } afs_supply_s;

   // live thermal, clock and channel conditions; index 0 is channel 1
   typedef struct packed {
      logic       warning_output_state;
      logic       fault_output_state;
      logic       clock_follower;
      logic       sync_clock_error;
      logic       overtemp_shutdown;
      logic [3:0] ch_overtemp_shutdown;
      logic [3:0] ch_load_current_limit;
   } afs_thermal_s;

   // one register access from the serial control engine
   typedef struct packed {
      afs_byte_t addr;
      logic      rd;
      logic      wr;
      afs_byte_t wdata;
   } afs_reg_req_s;

endpackage

/* rtl/afs_regs.sv */
/*
 * Read-only fault status and fault memory registers of a four-channel amplifier.
 * Assumes the serial control engine presents one-cycle read/write strobes and
 * that all live conditions are synchronous to clk.
 */
// Behaviour
// - supply status bit 7 reads 1 when any warning is active.
// - supply status bit 6 reads 1 when any fault is active.
// - supply status bit 5 shows live gate drive regulator fault.
// - supply status bit 3 shows power stage supply overvoltage.
// - supply status bit 2 shows battery supply overvoltage.
// - supply status bit 1 shows power stage supply undervoltage.
// - supply status bit 0 shows battery supply undervoltage.
// - thermal memory bit 5 stores sync clock faults, follower mode only.
// - thermal memory bit 4 stores global overtemp shutdown events.
// - thermal memory bits 3..0 store channel 1..4 overtemp shutdown events.
// - thermal status bit 7 mirrors the internal warning output state.
// - thermal status bit 6 mirrors the internal fault output state.
// - thermal status bit 5 shows live sync clock error in follower mode.
// - thermal status bit 4 shows global die overtemp shutdown.
// - thermal status bits 3..0 show channel 1..4 overtemp shutdown live.
// - reading load current memory returns content then clears it.
// - load current memory bits 3..0 store channel 1..4 limit faults.
`timescale 1ns/1ns
`default_nettype none
`include "afs_defines.svh"

module afs_regs (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire afs_pkg::afs_supply_s  supply_in,
   input  wire afs_pkg::afs_thermal_s thermal_in,
   input  wire logic                  stored_clear,
   input  wire afs_pkg::afs_reg_req_s reg_req,
   output var  afs_pkg::afs_byte_t    reg_rdata,
   output logic                       reg_rvalid,
   output logic [3:0]                 load_current_fault_stored
);

   ////////////////////////////////////////////////////////////////////////////
   // state

   afs_pkg::afs_byte_t sup_q;
   afs_pkg::afs_byte_t sup_d;
   afs_pkg::afs_byte_t tcs_q;
   afs_pkg::afs_byte_t tcs_d;
   logic [5:0]         tcm_q;
   logic [5:0]         tcm_d;
   logic [3:0]         lcm_q;
   logic [3:0]         lcm_d;
   afs_pkg::afs_byte_t rdata_q;
   afs_pkg::afs_byte_t rdata_d;
   logic               rvalid_q;
   logic               rvalid_d;

   logic [3:0]         ch_overtemp_shutdown_bits;
   logic [3:0]         ch_limit_bits;
   logic               clk_err_live;
   logic               fault_local;
   logic               rd_load_mem;

   ////////////////////////////////////////////////////////////////////////////
   // channel remap: channel 1 sits in bit 3

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_ch
         assign ch_overtemp_shutdown_bits[`AFS_TC_CH_MSB - gi]  = thermal_in.ch_overtemp_shutdown[gi];
         assign ch_limit_bits[`AFS_TC_CH_MSB - gi] = thermal_in.ch_load_current_limit[gi];
      end
   endgenerate

   // clock error counts only as a clock follower
   assign clk_err_live = thermal_in.clock_follower & thermal_in.sync_clock_error;

   assign fault_local = supply_in.gate_drive_regulator_fault
                      | supply_in.power_stage_supply_ov
                      | supply_in.battery_supply_ov
                      | supply_in.power_stage_supply_uv
                      | supply_in.battery_supply_uv
                      | thermal_in.overtemp_shutdown
                      | (|thermal_in.ch_overtemp_shutdown)
                      | (|thermal_in.ch_load_current_limit)
                      | clk_err_live;

   assign rd_load_mem = reg_req.rd && (reg_req.addr == `AFS_ADDR_LOAD_MEM);

   ////////////////////////////////////////////////////////////////////////////
   // live status snapshots

   always_comb begin
      sup_d                      = `AFS_RST_BYTE;
      sup_d[`AFS_SUP_WARN_BIT]   = supply_in.any_warning;
      sup_d[`AFS_SUP_FAULT_BIT]  = supply_in.any_fault | fault_local;
      sup_d[`AFS_SUP_GATE_BIT]   = supply_in.gate_drive_regulator_fault;
      sup_d[`AFS_SUP_PS_OV_BIT]  = supply_in.power_stage_supply_ov;
      sup_d[`AFS_SUP_BAT_OV_BIT] = supply_in.battery_supply_ov;
      sup_d[`AFS_SUP_PS_UV_BIT]  = supply_in.power_stage_supply_uv;
      sup_d[`AFS_SUP_BAT_UV_BIT] = supply_in.battery_supply_uv;
      tcs_d                      = `AFS_RST_BYTE;
      tcs_d[`AFS_TC_WARN_BIT]    = thermal_in.warning_output_state;
      tcs_d[`AFS_TC_FAULT_BIT]   = thermal_in.fault_output_state;
      tcs_d[`AFS_TC_CLK_BIT]     = clk_err_live;
      tcs_d[`AFS_TC_OVERTEMP_SHUTDOWN_BIT]    = thermal_in.overtemp_shutdown;
      tcs_d[`AFS_TC_CH_MSB:0]    = ch_overtemp_shutdown_bits;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sup_q <= `AFS_RST_BYTE;
         tcs_q <= `AFS_RST_BYTE;
      end else begin
         sup_q <= sup_d;
         tcs_q <= tcs_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // fault memories; a new event beats a clear in the same cycle

   always_comb begin
      tcm_d = tcm_q;
      if (stored_clear) begin
         tcm_d = `AFS_RST_THERMAL_MEM;
      end
      tcm_d = tcm_d | {clk_err_live, thermal_in.overtemp_shutdown, ch_overtemp_shutdown_bits};
      lcm_d = lcm_q;
      if (rd_load_mem) begin
         lcm_d = `AFS_RST_LOAD_MEM;
      end
      lcm_d = lcm_d | ch_limit_bits;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tcm_q <= `AFS_RST_THERMAL_MEM;
         lcm_q <= `AFS_RST_LOAD_MEM;
      end else begin
         tcm_q <= tcm_d;
         lcm_q <= lcm_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read port; writes never reach any register

   always_comb begin
      rdata_d  = rdata_q;
      rvalid_d = reg_req.rd;
      if (reg_req.rd) begin
         case (reg_req.addr)
            `AFS_ADDR_SUPPLY_STATUS:  rdata_d = sup_q;
            `AFS_ADDR_THERMAL_MEM:    rdata_d = {2'h0, tcm_q};
            `AFS_ADDR_THERMAL_STATUS: rdata_d = tcs_q;
            `AFS_ADDR_LOAD_MEM:       rdata_d = {4'h0, lcm_q};
            default:                  rdata_d = `AFS_READ_ZERO;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q  <= `AFS_RST_BYTE;
         rvalid_q <= 1'b0;
      end else begin
         rdata_q  <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   assign reg_rdata                 = rdata_q;
   assign reg_rvalid                = rvalid_q;
   assign load_current_fault_stored = lcm_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_rd_supply;
      reg_req.rd && (reg_req.addr == `AFS_ADDR_SUPPLY_STATUS);
   endsequence

   sequence s_rd_load;
      reg_req.rd && (reg_req.addr == `AFS_ADDR_LOAD_MEM);
   endsequence

   sequence s_rd_tmem;
      reg_req.rd && (reg_req.addr == `AFS_ADDR_THERMAL_MEM);
   endsequence

   property p_glob_warn;
      supply_in.any_warning ##1 s_rd_supply |=> reg_rdata[7];
   endproperty
   a_glob_warn: assert property (p_glob_warn) else $error("warning summary missing");

   property p_glob_warn_off;
      !supply_in.any_warning |=> !sup_q[7];
   endproperty
   a_glob_warn_off: assert property (p_glob_warn_off) else $error("stale warning");

   property p_glob_fault;
      (supply_in.gate_drive_regulator_fault || thermal_in.overtemp_shutdown) |=> sup_q[6];
   endproperty
   a_glob_fault: assert property (p_glob_fault) else $error("fault summary missing");

   property p_glob_fault_off;
      !supply_in.any_fault && !fault_local |=> !sup_q[6];
   endproperty
   a_glob_fault_off: assert property (p_glob_fault_off) else $error("stale fault");

   property p_gate;
      1'b1 |=> sup_q[5] == $past(supply_in.gate_drive_regulator_fault);
   endproperty
   a_gate: assert property (p_gate) else $error("regulator fault bit wrong");

   property p_ps_ov;
      supply_in.power_stage_supply_ov ##1 s_rd_supply |=> reg_rdata[3];
   endproperty
   a_ps_ov: assert property (p_ps_ov) else $error("power stage ov not read");

   property p_bat_ov;
      1'b1 |=> sup_q[2] == $past(supply_in.battery_supply_ov);
   endproperty
   a_bat_ov: assert property (p_bat_ov) else $error("battery ov bit wrong");

   property p_ps_uv;
      1'b1 |=> sup_q[1] == $past(supply_in.power_stage_supply_uv);
   endproperty
   a_ps_uv: assert property (p_ps_uv) else $error("power stage uv bit wrong");

   property p_bat_uv;
      supply_in.battery_supply_uv ##1 s_rd_supply |=> reg_rdata[0];
   endproperty
   a_bat_uv: assert property (p_bat_uv) else $error("battery uv not read");

   property p_clk_mem;
      thermal_in.clock_follower && thermal_in.sync_clock_error |=> tcm_q[5];
   endproperty
   a_clk_mem: assert property (p_clk_mem) else $error("clock fault not stored");

   property p_clk_mem_leader;
      !thermal_in.clock_follower && !tcm_q[5] |=> !tcm_q[5];
   endproperty
   a_clk_mem_leader: assert property (p_clk_mem_leader) else $error("clock fault as leader");

   property p_overtemp_shutdown_mem;
      thermal_in.overtemp_shutdown ##1 s_rd_tmem |=> reg_rdata[4];
   endproperty
   a_overtemp_shutdown_mem: assert property (p_overtemp_shutdown_mem) else $error("global shutdown not stored");

   property p_ch_overtemp_shutdown_mem;
      thermal_in.ch_overtemp_shutdown[0] |=> tcm_q[3];
   endproperty
   a_ch_overtemp_shutdown_mem: assert property (p_ch_overtemp_shutdown_mem) else $error("channel 1 shutdown lost");

   property p_warn_sig;
      1'b1 |=> tcs_q[7] == $past(thermal_in.warning_output_state);
   endproperty
   a_warn_sig: assert property (p_warn_sig) else $error("warning state mirror wrong");

   property p_fault_sig;
      1'b1 |=> tcs_q[6] == $past(thermal_in.fault_output_state);
   endproperty
   a_fault_sig: assert property (p_fault_sig) else $error("fault state mirror wrong");

   property p_clk_live;
      1'b1 |=> tcs_q[5] == $past(clk_err_live);
   endproperty
   a_clk_live: assert property (p_clk_live) else $error("clock error bit wrong");

   property p_overtemp_shutdown_live;
      1'b1 |=> tcs_q[4] == $past(thermal_in.overtemp_shutdown);
   endproperty
   a_overtemp_shutdown_live: assert property (p_overtemp_shutdown_live) else $error("global shutdown bit wrong");

   property p_ch_live;
      thermal_in.ch_overtemp_shutdown == 4'h1 |=> tcs_q[3:0] == 4'h8;
   endproperty
   a_ch_live: assert property (p_ch_live) else $error("channel order wrong");

   property p_rc_read;
      s_rd_load and !(|thermal_in.ch_load_current_limit)
         |=> (reg_rdata == {4'h0, $past(lcm_q)}) && (lcm_q == 4'h0);
   endproperty
   a_rc_read: assert property (p_rc_read) else $error("read-clear failed");

   property p_rc_set_wins;
      s_rd_load and thermal_in.ch_load_current_limit[0] |=> lcm_q[3];
   endproperty
   a_rc_set_wins: assert property (p_rc_set_wins) else $error("event lost on read");

   property p_limit_mem;
      thermal_in.ch_load_current_limit[3] |=> lcm_q[0];
   endproperty
   a_limit_mem: assert property (p_limit_mem) else $error("channel 4 limit lost");

   property p_lcm_hold;
      lcm_q[3] && !reg_req.rd [*2] |=> lcm_q[3];
   endproperty
   a_lcm_hold: assert property (p_lcm_hold) else $error("load fault dropped");

   property p_tcm_hold;
      tcm_q[4] && !stored_clear |=> tcm_q[4];
   endproperty
   a_tcm_hold: assert property (p_tcm_hold) else $error("shutdown memory dropped");

   property p_write_ignored;
      reg_req.wr && !reg_req.rd |=> $stable(reg_rdata) && !reg_rvalid;
   endproperty
   a_write_ignored: assert property (p_write_ignored) else $error("write had effect");

   property p_reserved;
      s_rd_supply or s_rd_load |=> !reg_rdata[4] && reg_rvalid;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit set");

   property p_tmem_reserved;
      s_rd_tmem |=> reg_rdata[7:6] == 2'h0;
   endproperty
   a_tmem_reserved: assert property (p_tmem_reserved) else $error("reserved bits set");

   property p_tcm_clear;
      stored_clear && !clk_err_live && !thermal_in.overtemp_shutdown
         && (ch_overtemp_shutdown_bits == 4'h0) |=> tcm_q == 6'h00;
   endproperty
   a_tcm_clear: assert property (p_tcm_clear) else $error("shutdown memory not cleared");

   property p_lcm_keep;
      lcm_q[0] && !rd_load_mem |=> lcm_q[0];
   endproperty
   a_lcm_keep: assert property (p_lcm_keep) else $error("channel 4 limit dropped");

   property p_lcm_write;
      reg_req.wr && !reg_req.rd && (lcm_q != 4'h0) |=> lcm_q != 4'h0;
   endproperty
   a_lcm_write: assert property (p_lcm_write) else $error("write cleared load memory");

   property p_unmapped;
      reg_req.rd && (reg_req.addr > `AFS_ADDR_LOAD_MEM) |=> reg_rdata == `AFS_READ_ZERO;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

endmodule

`default_nettype wire

/* sim/afs_host_model.sv */
/*
 * Host controller model: issues single-byte reads and writes on the register
 * port and pulses the stored-fault clear.
 * Assumes clk from the bench; requests change on the falling edge only.
 */
`timescale 1ns/1ns
`default_nettype none

module afs_host_model (
   input  wire logic                 clk,
   output var  afs_pkg::afs_reg_req_s reg_req,
   output var  logic                 stored_clear,
   input  wire afs_pkg::afs_byte_t    reg_rdata,
   input  wire logic                 reg_rvalid
);

   initial begin
      reg_req      = '0;
      stored_clear = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // one-cycle read strobe, bounded wait for the answer
   task automatic read_reg(input afs_pkg::afs_byte_t addr, output afs_pkg::afs_byte_t data,
                           output logic ok);
      int n;
      ok   = 1'b0;
      data = 8'h00;
      @(negedge clk);
      reg_req.addr = addr;
      reg_req.rd   = 1'b1;
      @(negedge clk);
      reg_req.rd   = 1'b0;
      reg_req.addr = ~addr;
      for (n = 0; n < 4 && !ok; n++) begin
         if (reg_rvalid === 1'b1) begin
            ok   = 1'b1;
            data = reg_rdata;
         end else begin
            @(negedge clk);
         end
      end
   endtask

   // one-cycle write strobe; data released inverted afterwards
   task automatic write_reg(input afs_pkg::afs_byte_t addr, input afs_pkg::afs_byte_t data);
      @(negedge clk);
      reg_req.addr  = addr;
      reg_req.wdata = data;
      reg_req.wr    = 1'b1;
      @(negedge clk);
      reg_req.wr    = 1'b0;
      reg_req.addr  = ~addr;
      reg_req.wdata = ~data;
   endtask

   // one-cycle stored_clear pulse; clears the thermal fault memory only
   task automatic clear_faults;
      @(negedge clk);
      stored_clear = 1'b1;
      @(negedge clk);
      stored_clear = 1'b0;
   endtask

endmodule

`default_nettype wire

/* sim/amp_fault_status_regs_test.sv */
/*
 * Self-checking bench for the fault status register bank.
 * Assumes afs_regs and afs_host_model; inputs change on the falling edge.
 */
`timescale 1ns/1ns
`default_nettype none
`include "afs_defines.svh"

module amp_fault_status_regs_test;

   logic                  clk;
   logic                  rst_n;
   afs_pkg::afs_supply_s  sup;
   afs_pkg::afs_thermal_s th;
   afs_pkg::afs_reg_req_s req;
   logic                  clr;
   afs_pkg::afs_byte_t    rdata;
   logic                  rvalid;
   logic [3:0]            lcs;
   afs_pkg::afs_byte_t    mem_tc;
   afs_pkg::afs_byte_t    mem_lc;
   int                    n_errors;
   int                    n_checks;
   int                    i;

   afs_regs i_dut (
      .clk                       (clk),
      .rst_n                     (rst_n),
      .supply_in                 (sup),
      .thermal_in                (th),
      .stored_clear              (clr),
      .reg_req                   (req),
      .reg_rdata                 (rdata),
      .reg_rvalid                (rvalid),
      .load_current_fault_stored (lcs)
   );

   afs_host_model i_host (
      .clk          (clk),
      .reg_req      (req),
      .stored_clear (clr),
      .reg_rdata    (rdata),
      .reg_rvalid   (rvalid)
   );

   always #5 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////
   // expectations
   function automatic logic [3:0] rev4(input logic [3:0] v);
      return {v[0], v[1], v[2], v[3]};
   endfunction

   // thermal-side fault sources that also feed the global fault bit
   function automatic logic amb(input afs_pkg::afs_thermal_s t);
      return t.overtemp_shutdown | (|t.ch_overtemp_shutdown)
           | (t.clock_follower & t.sync_clock_error) | (|t.ch_load_current_limit);
   endfunction

   function automatic afs_pkg::afs_byte_t exp_sup(input afs_pkg::afs_supply_s s,
                                                  input afs_pkg::afs_thermal_s t);
      logic loc;
      loc = s.gate_drive_regulator_fault | s.power_stage_supply_ov | s.battery_supply_ov
          | s.power_stage_supply_uv | s.battery_supply_uv | amb(t);
      return {s.any_warning, s.any_fault | loc, s.gate_drive_regulator_fault, 1'b0,
              s.power_stage_supply_ov, s.battery_supply_ov, s.power_stage_supply_uv,
              s.battery_supply_uv};
   endfunction

   function automatic afs_pkg::afs_byte_t ev_tc(input afs_pkg::afs_thermal_s t);
      return {2'b00, t.clock_follower & t.sync_clock_error, t.overtemp_shutdown,
              rev4(t.ch_overtemp_shutdown)};
   endfunction

   function automatic afs_pkg::afs_byte_t exp_ts(input afs_pkg::afs_thermal_s t);
      afs_pkg::afs_byte_t ev;
      ev = ev_tc(t);
      return {t.warning_output_state, t.fault_output_state, ev[5:0]};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // checks and stimulus
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [7:0] e, input logic [7:0] s,
                        input logic [7:0] m);
      n_checks++;
      if ((s & m) !== (e & m)) begin
         $display("ERROR %s expected %h seen %h", name, e, s);
         n_errors++;
      end
   endtask

   task automatic rd_check(input afs_pkg::afs_byte_t a, input afs_pkg::afs_byte_t e,
                           input afs_pkg::afs_byte_t m);
      afs_pkg::afs_byte_t d;
      logic               ok;
      i_host.read_reg(a, d, ok);
      if (!ok) begin
         $display("ERROR rvalid timeout expected 1 seen 0");
         n_errors++;
         conclude();
      end else begin
         check($sformatf("reg %h", a), e, d, m);
      end
   endtask

   task automatic apply(input logic [19:0] v);
      @(negedge clk);
      {sup, th} = v;
      repeat (2) @(negedge clk);
      mem_tc = mem_tc | ev_tc(th);
      mem_lc = mem_lc | {4'h0, rev4(th.ch_load_current_limit)};
   endtask

   task automatic check_all;
      rd_check(`AFS_ADDR_SUPPLY_STATUS, exp_sup(sup, th), 8'hFF);
      rd_check(`AFS_ADDR_THERMAL_MEM, mem_tc, 8'hFF);
      rd_check(`AFS_ADDR_THERMAL_STATUS, exp_ts(th), 8'hFF);
      rd_check(`AFS_ADDR_LOAD_MEM, mem_lc, 8'hFF);
      mem_lc = {4'h0, rev4(th.ch_load_current_limit)};
      check("stored copy", {4'h0, mem_lc[3:0]}, {4'h0, lcs}, 8'hFF);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      void'($urandom(32'hB0C7));
      clk      = 1'b0;
      rst_n    = 1'b0;
      {sup, th} = 20'h00000;
      n_errors = 0;
      n_checks = 0;
      mem_tc   = 8'h00;
      mem_lc   = 8'h00;
      repeat (3) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;

      check_all();
      rd_check(8'h10, 8'h00, 8'hFF);
      rd_check(8'h15, 8'h00, 8'hFF);
      rd_check(8'hFF, 8'h00, 8'hFF);
      $display("test reset values done");

      apply(20'h01FFF);
      apply(20'h00000);
      check_all();
      check_all();
      i_host.clear_faults();
      mem_tc = 8'h00;
      check_all();
      $display("test sticky and clear done");

      apply(20'h0FFFF);
      for (i = 0; i < 4; i++) begin
         i_host.write_reg(8'h11 + 8'(i), 8'h00);
         i_host.write_reg(8'h12 + 8'(i), 8'hFF);
      end
      check_all();
      $display("test writes ignored done");

      for (i = 0; i < 20; i++) begin
         apply(20'h00001 << i);
         check_all();
      end
      $display("test single bit walk done");

      for (i = 0; i < 60; i++) begin
         apply(20'($urandom & $urandom));
         check_all();
         if (i % 8 == 7) begin
            i_host.clear_faults();
            mem_tc = ev_tc(th);
            rd_check(`AFS_ADDR_THERMAL_MEM, mem_tc, 8'hFF);
         end
      end
      $display("test random traffic done");
      conclude();
   end

endmodule

`default_nettype wire
